/* rtl/macag_pkg.sv */
// Shared constants and types for the coprocessor operand address pipeline
`default_nettype none
package macag_pkg;
    // ==================================================
    // Widths
    localparam int MACAG_AW = 16;                      // Pointer and address width
    localparam int MACAG_RW = 13;                      // Repeat count width
    // ==================================================
    // Instruction double-word field layout
    localparam int F_OP_LO = 29;                       // Operation class [31:29]
    localparam int F_GSEL_LO = 25;                     // General register select [28:25]
    localparam int F_GMODE_LO = 22;                    // General pointer mode [24:22]
    localparam int F_GOFF = 21;                        // General offset select
    localparam int F_XSEL = 20;                        // Index pointer select
    localparam int F_XMODE_LO = 17;                    // Index pointer mode [19:17]
    localparam int F_XOFF = 16;                        // Index offset select
    localparam int F_REP = 15;                         // Repeat enable
    localparam int F_CNT_LO = 0;                       // Repeat count [12:0]
    // ==================================================
    // Arithmetic and address constants
    localparam logic [15:0] PM_STEP = 16'h0002;        // Fixed step of +/- modes
    localparam logic [15:0] RAM_LO = 16'hFA00;         // Dual-port RAM low bound
    localparam logic [15:0] RAM_HI = 16'hFDFF;         // Dual-port RAM high bound
    localparam logic [15:0] PTR_RST = 16'h0000;        // Pointer reset value
    localparam logic [12:0] CNT_ZERO = 13'h0000;       // Repeat count end value
    localparam logic [12:0] CNT_ONE = 13'h0001;        // Repeat decrement
    // ==================================================
    // Pointer configuration write selects
    localparam logic [2:0] CFG_IDX_A = 3'h0;           // index_pointer_a
    localparam logic [2:0] CFG_IDX_B = 3'h1;           // index_pointer_b
    localparam logic [2:0] CFG_GOFF_A = 3'h2;          // gpr_offset_a
    localparam logic [2:0] CFG_GOFF_B = 3'h3;          // gpr_offset_b
    localparam logic [2:0] CFG_XOFF_A = 3'h4;          // index_offset_a
    localparam logic [2:0] CFG_XOFF_B = 3'h5;          // index_offset_b
    // ==================================================
    // Types
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_MAC = 3'h1,
        OP_MAC_WITH_PARALLEL_MOVE = 3'h2,
        OP_TABLE_MEM_MOVE = 3'h3,
        OP_COPROC_REG_STORE = 3'h4
    } macag_op_t;
    typedef enum logic [2:0] {
        PM_NONE = 3'h0,
        PM_INC2 = 3'h1,
        PM_DEC2 = 3'h2,
        PM_ADD_OFF = 3'h3,
        PM_SUB_OFF = 3'h4
    } macag_pmode_t;
    // Repeat sequencer, Gray coded along idle -> run -> stopped
    typedef enum logic [1:0] {
        RP_IDLE = 2'b00,
        RP_RUN = 2'b01,
        RP_STOP = 2'b11
    } macag_rep_t;
endpackage
`default_nettype wire

/* rtl/macag_ptr_if.sv */
// Carrier between the pipeline and a pointer post-modification unit
`default_nettype none
interface macag_ptr_if;
    import macag_pkg::*;
    logic [15:0] ptr;         // Pointer value used as operand address
    logic [15:0] offset;      // Selected offset register
    macag_pmode_t mode;       // Post-modification mode
    logic [15:0] nextPtr;     // Post-modified pointer
    logic [15:0] revAddr;     // Pointer under the inverse modification
    modport calc (input ptr, input offset, input mode, output nextPtr, output revAddr);
    modport user (output ptr, output offset, output mode, input nextPtr, input revAddr);
endinterface
`default_nettype wire

/* rtl/macag_postmod.sv */
// Pointer post-modification and its inverse for one pointer
`default_nettype none
module macag_postmod
    import macag_pkg::*;
(
    // Pointer carrier
    macag_ptr_if.calc p
);
    // ==================================================
    // Modification arithmetic; 16-bit sums wrap silently
    always_comb begin
        case (p.mode)
            PM_INC2: begin
                p.nextPtr = p.ptr + PM_STEP;
                p.revAddr = p.ptr - PM_STEP;
            end
            PM_DEC2: begin
                p.nextPtr = p.ptr - PM_STEP;
                p.revAddr = p.ptr + PM_STEP;
            end
            PM_ADD_OFF: begin
                p.nextPtr = p.ptr + p.offset;
                p.revAddr = p.ptr - p.offset;
            end
            PM_SUB_OFF: begin
                p.nextPtr = p.ptr - p.offset;
                p.revAddr = p.ptr + p.offset;
            end
            default: begin
                // No-op mode leaves the pointer and targets itself
                p.nextPtr = p.ptr;
                p.revAddr = p.ptr;
            end
        endcase
    end
endmodule
`default_nettype wire

/* rtl/macag_pipe.sv */
// Coprocessor operand address generation and four-stage sequencing
`default_nettype none
module macag_pipe
    import macag_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Instruction issue from the core
    input wire logic instrValid,
    output logic instrReady,
    input wire logic [31:0] instrWord,
    // Pointer configuration writes
    input wire logic cfgWrEn,
    input wire logic [2:0] cfgWrSel,
    input wire logic [15:0] cfgWrData,
    // General register file read and write
    output logic [3:0] gprRdAddr,
    input wire logic [15:0] gprRdData,
    output logic gprWrEn,
    output logic [3:0] gprWrAddr,
    output logic [15:0] gprWrData,
    // Operand fetch in decode
    output logic opRdEn,
    output logic [15:0] opAddrGpr,
    output logic [15:0] opAddrIdx,
    output logic idxRangeErr,
    input wire logic [15:0] opDataIdx,
    // Execute-stage strobes and flags
    output logic accUpdate,
    output logic regStoreEn,
    input wire logic [3:0] macFlags,
    input wire logic [3:0] flagMask,
    output logic trapReq,
    // Parallel move write-back
    output logic moveWrEn,
    output logic [15:0] moveWrAddr,
    output logic [15:0] moveWrData,
    // Repeat control
    input wire logic irqStop,
    output logic repeatActive,
    output logic repeatStopped,
    output logic [12:0] repRemain
);
    // ==================================================
    // Pipeline state
    logic feValid_q, feValid_d;                  // Fetch stage holds a double-word
    logic [31:0] feInstr_q, feInstr_d;           // Fetched double-word
    logic deValid_q, deValid_d;                  // Decode stage occupied
    macag_op_t deOp_q, deOp_d;                   // Decode operation
    logic [3:0] deGSel_q, deGSel_d;              // Decode general register
    macag_pmode_t deGMode_q, deGMode_d;          // Decode general mode
    logic deGOff_q, deGOff_d;                    // Decode general offset select
    logic deXSel_q, deXSel_d;                    // Decode index pointer select
    macag_pmode_t deXMode_q, deXMode_d;          // Decode index mode
    logic deXOff_q, deXOff_d;                    // Decode index offset select
    logic [15:0] deGPtr_q, deGPtr_d;             // General operand address
    logic [15:0] deXPtr_q, deXPtr_d;             // Index operand address
    logic deErr_q, deErr_d;                      // Index address out of range
    macag_rep_t rep_q, rep_d;                    // Repeat sequencer state
    logic [12:0] repCnt_q, repCnt_d;             // Remaining repeat count
    logic exValid_q, exValid_d;                  // Execute stage occupied
    macag_op_t exOp_q, exOp_d;                   // Execute operation
    logic exGWr_q, exGWr_d;                      // General pointer write pending
    logic [3:0] exGSel_q, exGSel_d;              // Register to write
    logic [15:0] exGData_q, exGData_d;           // Modified general pointer
    logic exMove_q, exMove_d;                    // Parallel move in flight
    logic [15:0] exMAddr_q, exMAddr_d;           // Move target address
    logic [15:0] exMData_q, exMData_d;           // Moved operand
    logic wbMove_q, wbMove_d;                    // Writeback store strobe
    logic [15:0] wbAddr_q, wbAddr_d;             // Writeback address
    logic [15:0] wbData_q, wbData_d;             // Writeback data
    logic trap_q, trap_d;                        // Trap request
    logic [1:0][15:0] idxPtr_q, idxPtr_d;        // index_pointer_a/b
    logic [1:0][15:0] gOff_q, gOff_d;            // gpr_offset_a/b
    logic [1:0][15:0] xOff_q, xOff_d;            // index_offset_a/b
    // ==================================================
    // Fetch-stage fields and helpers
    macag_op_t feOp;
    logic feUses, deUses, deStay, deFree, feMove, feLoad;
    logic [15:0] feGVal, feXVal, nxtG, nxtX;
    // Post-modification units, general (0) and index (1)
    macag_ptr_if pm[2] ();
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gPm
            macag_postmod uPm (
                .p(pm[g])
            );
        end
    endgenerate
    // Operands of the units come from the decode stage
    assign pm[0].ptr = deGPtr_q;
    assign pm[0].offset = gOff_q[deGOff_q];
    assign pm[0].mode = deGMode_q;
    assign pm[1].ptr = deXPtr_q;
    assign pm[1].offset = xOff_q[deXOff_q];
    assign pm[1].mode = deXMode_q;
    // ==================================================
    // Stage flow
    always_comb begin
        feOp = macag_op_t'(feInstr_q[F_OP_LO +: 3]);
        // Only the double-indirect classes touch pointers
        feUses = (feOp == OP_MAC) || (feOp == OP_MAC_WITH_PARALLEL_MOVE) ||
                 (feOp == OP_TABLE_MEM_MOVE);
        deUses = deValid_q && ((deOp_q == OP_MAC) ||
                 (deOp_q == OP_MAC_WITH_PARALLEL_MOVE) || (deOp_q == OP_TABLE_MEM_MOVE));
        // Decode holds while a repeat has iterations left and no interrupt
        deStay = deValid_q && (rep_q == RP_RUN) && (repCnt_q != CNT_ZERO) && !irqStop;
        deFree = !deStay;
        feMove = feValid_q && deFree;
        instrReady = !feValid_q || feMove;
        feLoad = instrValid && instrReady;
    end
    // ==================================================
    // Operand forwarding into decode; newest producer wins
    always_comb begin
        gprRdAddr = feInstr_q[F_GSEL_LO +: 4];
        feGVal = gprRdData;
        // A pointer written back this cycle has not reached the register file yet
        if (exValid_q && exGWr_q && (exGSel_q == gprRdAddr)) begin
            feGVal = exGData_q;
        end
        if (deUses && (deGSel_q == gprRdAddr)) begin
            feGVal = pm[0].nextPtr;
        end
        feXVal = idxPtr_q[feInstr_q[F_XSEL]];
        if (deUses && (deXSel_q == feInstr_q[F_XSEL])) begin
            feXVal = pm[1].nextPtr;
        end
        nxtG = deStay ? pm[0].nextPtr : feGVal;
        nxtX = deStay ? pm[1].nextPtr : feXVal;
    end
    // ==================================================
    // Next-state logic for all stages
    always_comb begin
        feValid_d = feValid_q;
        feInstr_d = feInstr_q;
        deValid_d = deValid_q;
        deOp_d = deOp_q;
        deGSel_d = deGSel_q;
        deGMode_d = deGMode_q;
        deGOff_d = deGOff_q;
        deXSel_d = deXSel_q;
        deXMode_d = deXMode_q;
        deXOff_d = deXOff_q;
        deGPtr_d = deGPtr_q;
        deXPtr_d = deXPtr_q;
        deErr_d = deErr_q;
        rep_d = rep_q;
        repCnt_d = repCnt_q;
        idxPtr_d = idxPtr_q;
        gOff_d = gOff_q;
        xOff_d = xOff_q;
        // Fetch: accept a new double-word, or empty into decode
        if (feLoad) begin
            feValid_d = 1'b1;
            feInstr_d = instrWord;
        end else if (feMove) begin
            feValid_d = 1'b0;
        end
        // Decode: a repeat iteration re-addresses from the modified pointers
        if (deStay) begin
            deGPtr_d = nxtG;
            deXPtr_d = nxtX;
            repCnt_d = repCnt_q - CNT_ONE;
        end else if (feMove) begin
            deValid_d = 1'b1;
            deOp_d = feOp;
            deGSel_d = feInstr_q[F_GSEL_LO +: 4];
            deGMode_d = feUses ? macag_pmode_t'(feInstr_q[F_GMODE_LO +: 3]) : PM_NONE;
            deGOff_d = feInstr_q[F_GOFF];
            deXSel_d = feInstr_q[F_XSEL];
            deXMode_d = feUses ? macag_pmode_t'(feInstr_q[F_XMODE_LO +: 3]) : PM_NONE;
            deXOff_d = feInstr_q[F_XOFF];
            deGPtr_d = nxtG;
            deXPtr_d = nxtX;
            if (feInstr_q[F_REP]) begin
                rep_d = RP_RUN;
                repCnt_d = feInstr_q[F_CNT_LO +: MACAG_RW];
            end else if (rep_q == RP_RUN) begin
                rep_d = RP_IDLE;
            end
        end else begin
            deValid_d = 1'b0;
            if (rep_q == RP_RUN) begin
                rep_d = RP_IDLE;
            end
        end
        // An interrupt ends the sequence early and keeps what is left
        if (deValid_q && (rep_q == RP_RUN) && (repCnt_q != CNT_ZERO) && irqStop) begin
            rep_d = RP_STOP;
            repCnt_d = repCnt_q - CNT_ONE;
        end
        // Index pointers may address only the dual-port RAM except in table moves
        deErr_d = deValid_d && (deOp_d != OP_TABLE_MEM_MOVE) &&
                  (deOp_d != OP_NONE) && (deOp_d != OP_COPROC_REG_STORE) &&
                  ((deXPtr_d < RAM_LO) || (deXPtr_d > RAM_HI));
        // Index pointer update happens at the end of decode
        if (deUses) begin
            idxPtr_d[deXSel_q] = pm[1].nextPtr;
        end
        // Software configuration writes take priority over post-modification
        for (int i = 0; i < 2; i++) begin
            if (cfgWrEn && (cfgWrSel == (i[0] ? CFG_IDX_B : CFG_IDX_A))) begin
                idxPtr_d[i] = cfgWrData;
            end
            if (cfgWrEn && (cfgWrSel == (i[0] ? CFG_GOFF_B : CFG_GOFF_A))) begin
                gOff_d[i] = cfgWrData;
            end
            if (cfgWrEn && (cfgWrSel == (i[0] ? CFG_XOFF_B : CFG_XOFF_A))) begin
                xOff_d[i] = cfgWrData;
            end
        end
        // Execute: every decoded iteration spends exactly one cycle here
        exValid_d = deValid_q;
        exOp_d = deOp_q;
        exGWr_d = deUses && (deGMode_q != PM_NONE);
        exGSel_d = deGSel_q;
        exGData_d = pm[0].nextPtr;
        exMove_d = deValid_q && (deOp_q == OP_MAC_WITH_PARALLEL_MOVE);
        exMAddr_d = pm[1].revAddr;
        exMData_d = opDataIdx;
        // Writeback carries the moved operand and nothing else
        wbMove_d = exValid_q && exMove_q;
        wbAddr_d = exMAddr_q;
        wbData_d = exMData_q;
        // Flags settle at the end of execute and raise the trap request
        trap_d = exValid_q && ((exOp_q == OP_MAC) || (exOp_q == OP_MAC_WITH_PARALLEL_MOVE)) &&
                 |(macFlags & flagMask);
    end
    // ==================================================
    // State registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            feValid_q <= 1'b0;
            feInstr_q <= 32'h0000_0000;
            deValid_q <= 1'b0;
            deOp_q <= OP_NONE;
            deGSel_q <= 4'h0;
            deGMode_q <= PM_NONE;
            deGOff_q <= 1'b0;
            deXSel_q <= 1'b0;
            deXMode_q <= PM_NONE;
            deXOff_q <= 1'b0;
            deGPtr_q <= PTR_RST;
            deXPtr_q <= PTR_RST;
            deErr_q <= 1'b0;
            rep_q <= RP_IDLE;
            repCnt_q <= CNT_ZERO;
            exValid_q <= 1'b0;
            exOp_q <= OP_NONE;
            exGWr_q <= 1'b0;
            exGSel_q <= 4'h0;
            exGData_q <= PTR_RST;
            exMove_q <= 1'b0;
            exMAddr_q <= PTR_RST;
            exMData_q <= PTR_RST;
            wbMove_q <= 1'b0;
            wbAddr_q <= PTR_RST;
            wbData_q <= PTR_RST;
            trap_q <= 1'b0;
            idxPtr_q <= {PTR_RST, PTR_RST};
            gOff_q <= {PTR_RST, PTR_RST};
            xOff_q <= {PTR_RST, PTR_RST};
        end else begin
            feValid_q <= feValid_d;
            feInstr_q <= feInstr_d;
            deValid_q <= deValid_d;
            deOp_q <= deOp_d;
            deGSel_q <= deGSel_d;
            deGMode_q <= deGMode_d;
            deGOff_q <= deGOff_d;
            deXSel_q <= deXSel_d;
            deXMode_q <= deXMode_d;
            deXOff_q <= deXOff_d;
            deGPtr_q <= deGPtr_d;
            deXPtr_q <= deXPtr_d;
            deErr_q <= deErr_d;
            rep_q <= rep_d;
            repCnt_q <= repCnt_d;
            exValid_q <= exValid_d;
            exOp_q <= exOp_d;
            exGWr_q <= exGWr_d;
            exGSel_q <= exGSel_d;
            exGData_q <= exGData_d;
            exMove_q <= exMove_d;
            exMAddr_q <= exMAddr_d;
            exMData_q <= exMData_d;
            wbMove_q <= wbMove_d;
            wbAddr_q <= wbAddr_d;
            wbData_q <= wbData_d;
            trap_q <= trap_d;
            idxPtr_q <= idxPtr_d;
            gOff_q <= gOff_d;
            xOff_q <= xOff_d;
        end
    end
    // ==================================================
    // Outputs, all from stage registers
    assign opRdEn = deUses;
    assign opAddrGpr = deGPtr_q;
    assign opAddrIdx = deXPtr_q;
    assign idxRangeErr = deErr_q;
    assign gprWrEn = exValid_q && exGWr_q;
    assign gprWrAddr = exGSel_q;
    assign gprWrData = exGData_q;
    assign accUpdate = exValid_q &&
                       ((exOp_q == OP_MAC) || (exOp_q == OP_MAC_WITH_PARALLEL_MOVE));
    // Store reads in execute, so it sees results without a spacer
    assign regStoreEn = exValid_q && (exOp_q == OP_COPROC_REG_STORE);
    assign trapReq = trap_q;
    assign moveWrEn = wbMove_q;
    assign moveWrAddr = wbAddr_q;
    assign moveWrData = wbData_q;
    assign repeatActive = (rep_q == RP_RUN);
    assign repeatStopped = (rep_q == RP_STOP);
    assign repRemain = repCnt_q;
endmodule
`default_nettype wire

/* bench/macag_core_model.sv */
// Core-side model: register bank and operand RAM answers
`default_nettype none
module macag_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bank
    input wire logic [3:0] gprRdAddr,
    output logic [15:0] gprRdData,
    input wire logic gprWrEn,
    input wire logic [3:0] gprWrAddr,
    input wire logic [15:0] gprWrData,
    // Operand RAM
    input wire logic [15:0] opAddrIdx,
    output logic [15:0] opDataIdx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] bank [16]; // All registers start next to the wrap point
    // Same-cycle read, as the pipeline expects
    assign gprRdData = bank[gprRdAddr];
    // Data follows the address so each word differs
    assign opDataIdx = opAddrIdx ^ 16'hA5A5;
    // Pointer write-back lands at the clock edge
    always @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) bank[i] <= 16'hFFFE;
        end else if (gprWrEn) begin
            bank[gprWrAddr] <= gprWrData;
        end
    end
endmodule
`default_nettype wire

/* bench/macag_pipe_monitor.sv */
// Port checker for the operand address pipeline
`default_nettype none
module macag_pipe_monitor (
    // Clock, reset and issue
    input wire logic clk, rst_n, instrValid, instrReady, repeatActive,
    input wire logic [31:0] instrWord,
    // Stage outputs
    input wire logic opRdEn, idxRangeErr, accUpdate, regStoreEn, trapReq, moveWrEn, gprWrEn,
    input wire logic [15:0] opAddrGpr, opAddrIdx, opDataIdx, moveWrAddr, moveWrData, gprWrData,
    input wire logic [3:0] macFlags, flagMask
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Taken instruction, only while decode is free
    logic tk;
    logic [2:0] op, gm, xm;
    assign tk = instrValid && instrReady && !repeatActive;
    assign op = instrWord[31:29];
    assign gm = instrWord[24:22];
    assign xm = instrWord[19:17];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_decode_follow: assert property (tk && (op == 1 || op == 2) |-> ##2 opRdEn)
        else $error("no decode after take");
    a_exec_strobe: assert property (tk && (op == 1 || op == 2) |-> ##3 accUpdate)
        else $error("no execute after decode");
    a_store_strobe: assert property (tk && op == 4 |-> ##3 regStoreEn)
        else $error("store not executed");
    a_move_inc: assert property (tk && op == 2 && xm == 1 |-> ##4 moveWrEn
        && moveWrAddr == $past(opAddrIdx, 2) - 16'h0002)
        else $error("move target after +2 wrong");
    a_move_dec: assert property (tk && op == 2 && xm == 2 |-> ##4 moveWrEn
        && moveWrAddr == $past(opAddrIdx, 2) + 16'h0002)
        else $error("move target after -2 wrong");
    a_move_data: assert property (moveWrEn |-> moveWrData == $past(opDataIdx, 2))
        else $error("moved data wrong");
    a_move_only_wb: assert property (moveWrEn |-> $past(accUpdate))
        else $error("writeback without move");
    a_gpr_inc: assert property (tk && op == 2 && gm == 1 && !instrWord[15] |-> ##3 gprWrEn
        && gprWrData == $past(opAddrGpr) + 16'h0002)
        else $error("pointer +2 write wrong");
    a_trap_flags: assert property (accUpdate && (macFlags & flagMask) != 0 |=> trapReq)
        else $error("trap missing");
    a_trap_quiet: assert property (!accUpdate |=> !trapReq)
        else $error("trap without execute");
    a_range_err: assert property (idxRangeErr |-> opRdEn
        && (opAddrIdx < 16'hFA00 || opAddrIdx > 16'hFDFF))
        else $error("range flag inside RAM");
endmodule
bind macag_pipe macag_pipe_monitor macag_pipe_monitor_i (.*);
`default_nettype wire

/* bench/macag_pipe_tb_top.sv */
// Self-checking bench for the operand address pipeline
`default_nettype none
module macag_pipe_tb_top
    import macag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Stimulus, held at zero until driven
    logic clk = 0, rst_n = 0, instrValid = 0, cfgWrEn = 0, irqStop = 0;
    logic [31:0] instrWord = 0;
    logic [2:0] cfgWrSel = 0;
    logic [15:0] cfgWrData = 0;
    logic [3:0] macFlags = 0, flagMask = 0;
    // Design outputs and partner answers
    logic instrReady, gprWrEn, opRdEn, idxRangeErr, accUpdate, regStoreEn, trapReq;
    logic moveWrEn, repeatActive, repeatStopped;
    logic [3:0] gprRdAddr, gprWrAddr;
    logic [15:0] gprRdData, gprWrData, opAddrGpr, opAddrIdx, opDataIdx, moveWrAddr, moveWrData;
    logic [12:0] repRemain;
    // Captures of one run
    int failures = 0, total_checks = 0, nAcc, nTrap, nStore, nRange, nStop, nRun;
    logic [15:0] aIdx, aGpr, mvAddr, mvData, gData;
    logic [3:0] gAddr; // Register written by the last pointer write-back
    macag_pipe macag_pipe_i (.*);
    macag_core_model macag_core_model_i (.*);
    always #50 clk = ~clk;
    // ==========================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Register 3 with offset b, index offset b
    function automatic logic [31:0] mk(input logic [2:0] op, gm, xm, input logic xs, rep,
        input logic [12:0] cnt);
        return {op, 4'h3, gm, 1'b1, xs, xm, 1'b1, rep, 2'b00, cnt};
    endfunction
    task automatic cfg(input logic [2:0] sel, input logic [15:0] d);
        @(posedge clk);
        cfgWrEn <= 1'b1;
        cfgWrSel <= sel;
        cfgWrData <= d;
        @(posedge clk);
        cfgWrEn <= 1'b0;
    endtask
    // Issue one or two words back to back, then watch 30 cycles
    task automatic run(input logic [31:0] w1, w2, input int stopAt);
        bit dSeen, mSeen;
        {nAcc, nTrap, nStore, nRange, nStop, nRun, dSeen, mSeen} = '0;
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= w1;
        @(posedge clk);
        instrWord <= w2;
        instrValid <= (w2 != 0);
        @(posedge clk);
        instrValid <= 1'b0;
        for (int k = 0; k < 30; k++) begin
            irqStop <= (k == stopAt);
            #1;
            if (opRdEn && !dSeen) {aIdx, aGpr, dSeen} = {opAddrIdx, opAddrGpr, 1'b1};
            if (moveWrEn && !mSeen) {mvAddr, mvData, mSeen} = {moveWrAddr, moveWrData, 1'b1};
            if (gprWrEn) {gAddr, gData} = {gprWrAddr, gprWrData};
            nAcc += accUpdate;
            nTrap += trapReq;
            nStore += regStoreEn;
            nRange += idxRangeErr;
            nStop += repeatStopped;
            nRun += repeatActive;
            @(posedge clk);
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_modes();
        logic [15:0] ei[5] = '{16'hFA10, 16'hFA10, 16'hFA12, 16'hFA10, 16'hFA30};
        logic [15:0] em[5] = '{16'hFA10, 16'hFA0E, 16'hFA14, 16'hF9F0, 16'hFA50};
        logic [15:0] eg[6] = '{16'hFFFE, 16'hFFFE, 16'h0000, 16'hFFFE, 16'h000E, 16'hFFFE};
        cfg(CFG_IDX_A, 16'hFA10);
        cfg(CFG_IDX_B, 16'h1000);
        cfg(CFG_GOFF_B, 16'h0010);
        cfg(CFG_XOFF_B, 16'h0020);
        for (int m = 0; m < 5; m++) begin
            run(mk(OP_MAC_WITH_PARALLEL_MOVE, 3'(m), 3'(m), 0, 0, 0), 0, -1);
            chk(aIdx, ei[m]);
            chk(aGpr, eg[m]);
            chk(mvAddr, em[m]);
            chk(mvData, ei[m] ^ 16'hA5A5);
            if (m > 0) chk(gData, eg[m + 1]);
            if (m > 0) chk(16'(gAddr), 16'h0003);
        end
    endtask
    task automatic t_repeat();
        @(posedge clk);
        macFlags <= 4'h1;
        flagMask <= 4'h1;
        run(mk(OP_MAC, PM_NONE, PM_NONE, 1, 1, 13'h0003), 0, -1);
        chk(16'(nAcc), 16'h0004);
        chk(16'(nTrap), 16'h0004);
        chk(16'(nRange), 16'h0004);
        chk(16'(nRun), 16'h0004);
        macFlags <= 4'h0;
    endtask
    task automatic t_store();
        // Only the store may follow a MAC at once; other reads keep a spacer
        run(mk(OP_MAC, PM_NONE, PM_NONE, 0, 0, 0), mk(OP_COPROC_REG_STORE, 0, 0, 0, 0, 0), -1);
        chk(16'(nAcc), 16'h0001);
        chk(16'(nStore), 16'h0001);
    endtask
    task automatic t_stop();
        run(mk(OP_MAC, PM_NONE, PM_NONE, 0, 1, 13'h0007), 0, 3);
        #1;
        chk(16'(nStop), 16'h001A);
        chk(16'(nAcc), 16'h0004);
        chk(16'(repRemain), 16'h0003);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(instrReady), 16'h0001);
        t_modes();
        t_repeat();
        t_store();
        t_stop();
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
